// ===== core/clock_gen_i2c_config.sv
// Configuration loader that programs an external clock generator over I2C
`timescale 1ns/1ps
module clock_gen_i2c_config (
  // Clock and reset
  input  wire logic                  I_SYS_CLK,
  input  wire logic                  I_CTRL_RESET_N,
  // Control
  input  wire logic                  I_LAUNCH_CONFIG,
  input  wire clkgen_pkg::freq_sel_t I_FREQ_SEL,
  // Status
  output logic                       O_SETUP_COMPLETE,
  output logic                       O_ACK_ERROR,
  // I2C pins
  input  wire logic                  I_I2C_SDA_IN,
  output clkgen_pkg::i2c_pins_t      O_I2C
);
  import clkgen_pkg::*;

  localparam logic [4:0] QTR_MAX = 5'(SCL_QTR_CYC - 1);
  localparam logic [2:0] LAST_ENTRY = 3'(NUM_ENTRIES - 1);

  typedef struct packed {
    cfg_state_t st;
    logic [4:0] qcnt;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [1:0] byten;
    logic [2:0] entry;
    logic [7:0] shreg;
    logic [7:0] data;
    freq_sel_t  sel;
    logic [2:0] launch_sync;
    logic [1:0] sda_sync;
    logic       scl;
    logic       sda_oe_n;
    logic       done;
    logic       err;
  } state_t;

  localparam state_t STATE_RST = '{
    st:          ST_IDLE,
    qcnt:        5'h00,
    ph:          2'h0,
    bitn:        4'h0,
    byten:       2'h0,
    entry:       3'h0,
    shreg:       8'h00,
    data:        8'h00,
    sel:         FREQ_SEL_RST,
    launch_sync: 3'h0,
    sda_sync:    2'h3,
    scl:         1'b1,
    sda_oe_n:    1'b1,
    done:        1'b0,
    err:         1'b0
  };

  state_t     q;
  state_t     d;
  logic [7:0] rom_data;
  logic [3:0] rom_sel;
  logic       tick;
  logic       launch_edge;

  // ****************************************
  // Decoding helpers
  // ****************************************
  // Ninth slot of a byte belongs to the generator
  function automatic logic is_ack_slot(input logic [3:0] bit_idx);
    is_ack_slot = (bit_idx == ACK_BIT_IDX);
  endfunction : is_ack_slot

  // Quarter counter is held while no pass is running
  function automatic logic is_quiet(input cfg_state_t st);
    is_quiet = (st == ST_IDLE) || (st == ST_DONE);
  endfunction : is_quiet

  // Generator register written by a table entry
  function automatic logic [7:0] entry_reg_addr(input logic [2:0] entry);
    entry_reg_addr = CHAN_REG_BASE + {5'h00, entry};
  endfunction : entry_reg_addr

  // ****************************************
  // Channel selection for the table lookup
  // ****************************************
  always_comb begin
    unique case (q.entry[2:1])
      2'h0: rom_sel = q.sel.xcvr_chan0_freq_sel;
      2'h1: rom_sel = q.sel.xcvr_chan1_freq_sel;
      2'h2: rom_sel = q.sel.mem_chan0_freq_sel;
      2'h3: rom_sel = q.sel.mem_chan1_freq_sel;
    endcase
  end

  cfg_rom u_rom (
    .i_clk    (I_SYS_CLK),
    .i_is_mem (q.entry[2]),
    .i_sel    (rom_sel),
    .i_idx    (q.entry[0]),
    .o_data   (rom_data)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    // Two sync flops ahead of the edge detector
    d.launch_sync = {q.launch_sync[1:0], I_LAUNCH_CONFIG};
    d.sda_sync    = {q.sda_sync[0], I_I2C_SDA_IN};
    launch_edge   = q.launch_sync[1] & ~q.launch_sync[2];
    tick          = (q.qcnt == QTR_MAX);
    d.qcnt        = (is_quiet(q.st) || tick) ? 5'h00 : q.qcnt + 5'h01;

    unique case (q.st)
      ST_IDLE, ST_DONE: begin
        if (launch_edge) begin
          d.st    = ST_FETCH;
          d.entry = 3'h0;
          d.done  = 1'b0;
          d.err   = 1'b0;
          d.sel   = I_FREQ_SEL;
        end
      end
      ST_FETCH: begin
        if (tick) begin
          d.data  = rom_data;
          d.shreg = GEN_WR_ADDR;
          d.byten = 2'h0;
          d.bitn  = 4'h0;
          d.ph    = 2'h0;
          d.st    = ST_START;
        end
      end
      ST_START: begin
        if (tick) begin
          if (q.ph == 2'h0) begin
            d.sda_oe_n = 1'b0;
            d.ph       = 2'h1;
          end else begin
            d.scl = 1'b0;
            d.ph  = 2'h0;
            d.st  = ST_BIT;
          end
        end
      end
      ST_BIT: begin
        if (tick) begin
          d.ph = q.ph + 2'h1;
          unique case (q.ph)
            2'h0: d.sda_oe_n = is_ack_slot(q.bitn) ? 1'b1 : q.shreg[7];
            2'h1: d.scl = 1'b1;
            2'h2: begin
              if (is_ack_slot(q.bitn) && q.sda_sync[1]) begin
                d.err = 1'b1;
              end
            end
            2'h3: begin
              d.scl = 1'b0;
              if (is_ack_slot(q.bitn)) begin
                d.bitn = 4'h0;
                if (q.byten == LAST_BYTE_IDX) begin
                  d.st = ST_STOP;
                end else begin
                  d.byten = q.byten + 2'h1;
                  d.shreg = (q.byten == 2'h0) ? entry_reg_addr(q.entry) : q.data;
                end
              end else begin
                d.bitn  = q.bitn + 4'h1;
                d.shreg = {q.shreg[6:0], 1'b0};
              end
            end
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          d.ph = q.ph + 2'h1;
          unique case (q.ph)
            2'h0: d.sda_oe_n = 1'b0;
            2'h1: d.scl = 1'b1;
            2'h2: d.sda_oe_n = 1'b1;
            2'h3: begin
              d.ph = 2'h0;
              if (q.entry == LAST_ENTRY) begin
                d.st   = ST_DONE;
                d.done = 1'b1;
              end else begin
                d.entry = q.entry + 3'h1;
                d.st    = ST_FETCH;
              end
            end
          endcase
        end
      end
      default: d = STATE_RST;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_CTRL_RESET_N) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    O_SETUP_COMPLETE = q.done;
    O_ACK_ERROR      = q.err;
    O_I2C.scl        = q.scl;
    O_I2C.sda_out    = 1'b0;
    O_I2C.sda_oe_n   = q.sda_oe_n;
  end

endmodule : clock_gen_i2c_config

// ===== common/clkgen_pkg.sv
// Constants and types for the clock generator configuration loader
package clkgen_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_KHZ = 10000;
  localparam int I2C_SCL_KHZ = 100;
  localparam int SCL_QTR_CYC = (SYS_CLK_KHZ + 4 * I2C_SCL_KHZ - 1) / (4 * I2C_SCL_KHZ);

  // ****************************************
  // Bus framing and table layout
  // ****************************************
  localparam logic [7:0] GEN_WR_ADDR   = 8'hee;
  localparam logic [7:0] CHAN_REG_BASE = 8'h10;
  localparam int         NUM_ENTRIES   = 8;
  localparam logic [3:0] ACK_BIT_IDX   = 4'h8;
  localparam logic [1:0] LAST_BYTE_IDX = 2'h2;

  // ****************************************
  // Frequency selection codes
  // ****************************************
  localparam logic [3:0] XCVR_644M53125  = 4'h0;
  localparam logic [3:0] XCVR_322M265625 = 4'h1;
  localparam logic [3:0] XCVR_250M       = 4'h2;
  localparam logic [3:0] XCVR_125M       = 4'h3;
  localparam logic [3:0] XCVR_100M       = 4'h4;
  localparam logic [3:0] MEM_300M        = 4'h0;
  localparam logic [3:0] MEM_275M        = 4'h1;
  localparam logic [3:0] MEM_266M667     = 4'h2;
  localparam logic [3:0] MEM_233M333     = 4'h3;
  localparam logic [3:0] MEM_166M667     = 4'h4;
  localparam logic [3:0] FREQ_CODE_MAX   = 4'h4;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [3:0] mem_chan1_freq_sel;
    logic [3:0] mem_chan0_freq_sel;
    logic [3:0] xcvr_chan1_freq_sel;
    logic [3:0] xcvr_chan0_freq_sel;
  } freq_sel_t;

  typedef struct packed {
    logic scl;
    logic sda_out;
    logic sda_oe_n;
  } i2c_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_START,
    ST_BIT,
    ST_STOP,
    ST_DONE
  } cfg_state_t;

  localparam freq_sel_t FREQ_SEL_RST = '0;

endpackage : clkgen_pkg

// ===== core/cfg_rom.sv
// Register value table for the generator channels
`timescale 1ns/1ps
module cfg_rom (
  // Clock
  input  wire logic       i_clk,
  // Lookup
  input  wire logic       i_is_mem,
  input  wire logic [3:0] i_sel,
  input  wire logic       i_idx,
  // Registered value
  output logic      [7:0] o_data
);
  import clkgen_pkg::*;

  logic [3:0] sel_eff;

  always_comb begin
    sel_eff = (i_sel > FREQ_CODE_MAX) ? 4'h0 : i_sel;
  end

  // Two divider bytes per frequency, one table row per byte
  always_ff @(posedge i_clk) begin
    unique case ({i_is_mem, sel_eff, i_idx})
      {1'b0, XCVR_644M53125, 1'b0}  : o_data <= 8'h0a;
      {1'b0, XCVR_644M53125, 1'b1}  : o_data <= 8'h01;
      {1'b0, XCVR_322M265625, 1'b0} : o_data <= 8'h14;
      {1'b0, XCVR_322M265625, 1'b1} : o_data <= 8'h02;
      {1'b0, XCVR_250M, 1'b0}       : o_data <= 8'h1a;
      {1'b0, XCVR_250M, 1'b1}       : o_data <= 8'h03;
      {1'b0, XCVR_125M, 1'b0}       : o_data <= 8'h34;
      {1'b0, XCVR_125M, 1'b1}       : o_data <= 8'h04;
      {1'b0, XCVR_100M, 1'b0}       : o_data <= 8'h41;
      {1'b0, XCVR_100M, 1'b1}       : o_data <= 8'h05;
      {1'b1, MEM_300M, 1'b0}        : o_data <= 8'h16;
      {1'b1, MEM_300M, 1'b1}        : o_data <= 8'h11;
      {1'b1, MEM_275M, 1'b0}        : o_data <= 8'h18;
      {1'b1, MEM_275M, 1'b1}        : o_data <= 8'h12;
      {1'b1, MEM_266M667, 1'b0}     : o_data <= 8'h19;
      {1'b1, MEM_266M667, 1'b1}     : o_data <= 8'h13;
      {1'b1, MEM_233M333, 1'b0}     : o_data <= 8'h1c;
      {1'b1, MEM_233M333, 1'b1}     : o_data <= 8'h14;
      {1'b1, MEM_166M667, 1'b0}     : o_data <= 8'h27;
      {1'b1, MEM_166M667, 1'b1}     : o_data <= 8'h15;
      default                       : o_data <= 8'h00;
    endcase
  end

endmodule : cfg_rom

// ===== testbench/clock_gen_i2c_config_asserts.sv
// Port checker for the clock generator loader
`timescale 1ns/1ps
module clock_gen_i2c_config_asserts (
  // Clock, reset, control
  input wire logic                  I_SYS_CLK,
  input wire logic                  I_CTRL_RESET_N,
  input wire logic                  I_LAUNCH_CONFIG,
  input wire clkgen_pkg::freq_sel_t I_FREQ_SEL,
  // Status and bus
  input wire logic                  O_SETUP_COMPLETE,
  input wire logic                  O_ACK_ERROR,
  input wire logic                  I_I2C_SDA_IN,
  input wire clkgen_pkg::i2c_pins_t O_I2C
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_CTRL_RESET_N);
  property p_rst;
    disable iff (1'b0) !I_CTRL_RESET_N |=> !O_SETUP_COMPLETE && O_I2C.scl && O_I2C.sda_oe_n;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_start;
    $rose(I_LAUNCH_CONFIG) && O_SETUP_COMPLETE |-> ##[1:6] !O_SETUP_COMPLETE;
  endproperty
  a_start: assert property (p_start) else $error("launch edge ignored");
  property p_cause;
    $fell(O_SETUP_COMPLETE) |-> $past(I_LAUNCH_CONFIG) && !$past(I_LAUNCH_CONFIG, 8);
  endproperty
  a_cause: assert property (p_cause) else $error("pass without launch edge");
  property p_level;
    (O_SETUP_COMPLETE && I_LAUNCH_CONFIG) [*8] |=> O_SETUP_COMPLETE;
  endproperty
  a_level: assert property (p_level) else $error("level restarted pass");
  property p_idle;
    O_SETUP_COMPLETE |-> O_I2C.scl && O_I2C.sda_oe_n && !O_I2C.sda_out;
  endproperty
  a_idle: assert property (p_idle) else $error("bus busy when complete");
  property p_bus;
    $fell(O_SETUP_COMPLETE) |-> ##[1:200] !O_I2C.scl;
  endproperty
  a_bus: assert property (p_bus) else $error("no bus activity");
  property p_high;
    $rose(O_I2C.scl) |-> O_I2C.scl [*8];
  endproperty
  a_high: assert property (p_high) else $error("clock high too short");
  property p_clr;
    $fell(O_SETUP_COMPLETE) |-> ##[0:2] !O_ACK_ERROR;
  endproperty
  a_clr: assert property (p_clr) else $error("ack error not cleared");
endmodule : clock_gen_i2c_config_asserts
bind clock_gen_i2c_config clock_gen_i2c_config_asserts i_chk (.I_SYS_CLK(I_SYS_CLK),
  .I_CTRL_RESET_N(I_CTRL_RESET_N), .I_LAUNCH_CONFIG(I_LAUNCH_CONFIG), .I_FREQ_SEL(I_FREQ_SEL),
  .O_SETUP_COMPLETE(O_SETUP_COMPLETE), .O_ACK_ERROR(O_ACK_ERROR),
  .I_I2C_SDA_IN(I_I2C_SDA_IN), .O_I2C(O_I2C));

// ===== testbench/gen_model.sv
// Generator model that acks and records register writes
`timescale 1ns/1ps
module gen_model (
  // Bus
  input  wire logic  scl,
  input  wire logic  sda,
  input  wire logic  nack,
  output logic       pull_n,
  // Record
  output int         n_wr,
  output int         n_bad,
  output logic [7:0] data_q [8]
);
  int         bit_n = 0;
  int         byte_n = 0;
  logic [7:0] sh;
  logic [7:0] rg;
  initial pull_n = 1'b1;
  initial n_wr = 0;
  initial n_bad = 0;
  always @(negedge sda) if (scl) begin
    bit_n = 0;
    byte_n = 0;
  end
  always @(posedge scl) begin
    if (bit_n < 8) sh = {sh[6:0], sda};
    bit_n++;
  end
  always @(negedge scl) begin
    if (bit_n == 8) pull_n <= nack;
    if (bit_n == 9) begin
      pull_n <= 1'b1;
      bit_n = 0;
      if (byte_n == 0 && sh !== 8'hee) n_bad++;
      if (byte_n == 1) rg = sh;
      if (byte_n == 2) begin
        if (rg !== 8'(clkgen_pkg::CHAN_REG_BASE + n_wr % 8)) n_bad++;
        data_q[rg[2:0]] = sh;
        n_wr++;
      end
      byte_n++;
    end
  end
endmodule : gen_model

// ===== testbench/tb.sv
// Self-checking bench for the clock generator loader
`timescale 1ns/1ps
module tb;
  import clkgen_pkg::*;
  logic      clk = 0, rst_n = 0, launch = 0, nack = 0, pull_n, done, ackerr, sda;
  freq_sel_t sel = '0;
  freq_sel_t s1, s2;
  i2c_pins_t pins;
  int        n_fail = 0, n_checks = 0, seed = 68, cyc = 0, n_wr, n_bad;
  logic [7:0] d0 [8];
  logic [7:0] dq [8];
  always #50 clk = ~clk;
  assign sda = pins.sda_oe_n & pull_n;
  clock_gen_i2c_config i_dut (.I_SYS_CLK(clk), .I_CTRL_RESET_N(rst_n),
    .I_LAUNCH_CONFIG(launch), .I_FREQ_SEL(sel), .O_SETUP_COMPLETE(done),
    .O_ACK_ERROR(ackerr), .I_I2C_SDA_IN(sda), .O_I2C(pins));
  gen_model i_gen (.scl(pins.scl), .sda(sda), .nack(nack), .pull_n(pull_n),
    .n_wr(n_wr), .n_bad(n_bad), .data_q(dq));
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %0h got %0h", nm, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  function automatic freq_sel_t rnd_sel;
    for (int c = 0; c < 4; c++) rnd_sel[c*4+:4] = 4'(($random(seed) & 32'hffff) % 5);
  endfunction : rnd_sel
  task automatic run_pass(string nm, freq_sel_t s, logic glitch);
    int t = 0;
    @(posedge clk);
    sel <= s;
    launch <= 1'b1;
    repeat (8) @(negedge clk);
    chk("busy", 0, done);
    if (glitch) begin
      @(posedge clk);
      launch <= 1'b0;
      repeat (20) @(posedge clk);
      launch <= 1'b1;
    end
    while (done !== 1'b1 && t < 30000) begin
      @(negedge clk);
      t++;
    end
    chk("done", 1, done);
    chk("ack_flag", nack, ackerr);
    repeat (20) @(negedge clk);
    chk("level", 1, done);
    @(posedge clk);
    launch <= 1'b0;
    repeat (10) @(negedge clk);
    $display("test %s ended", nm);
  endtask : run_pass
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk);
    chk("rst_done", 0, done);
    s1 = 16'h4444;
    run_pass("max_codes", s1, 1'b0);
    chk("writes", 8, n_wr);
    d0 = dq;
    s2 = rnd_sel();
    run_pass("new_codes", s2, 1'b1);
    chk("writes2", 16, n_wr);
    for (int c = 0; c < 4; c++) begin
      chk("chan", s1[c*4+:4] == s2[c*4+:4], {d0[2*c], d0[2*c+1]} == {dq[2*c], dq[2*c+1]});
    end
    d0 = dq;
    nack <= 1'b1;
    run_pass("nack", s2, 1'b0);
    chk("ackerr", 1, ackerr);
    chk("same", 1, d0 == dq);
    chk("frames", 0, n_bad);
    @(posedge clk);
    launch <= 1'b1;
    repeat (1200) @(negedge clk);
    chk("mid_err", 1, ackerr);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(negedge clk);
    chk("mid_rst", 3'b010, {done, pins.scl, ackerr});
    $display("test mid_reset ended");
    tally_and_finish;
  end
endmodule : tb
